// File: src/edo_ctrl_pkg.sv
// Package with pin widths, timing constants and command codes of the memory controller.
package edo_ctrl_pkg;
	localparam int ROW_W = 10;
	localparam int COL_W = 10;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 4;
	localparam int CLK_MHZ = 20;
	localparam int CLK_NS = 50;
	// Least times in ns, rounded up to whole cycles.
	localparam int T_RP_NS = 60;
	localparam int T_RCD_NS = 60;
	localparam int T_CAS_NS = 20;
	localparam int T_RSH_NS = 20;
	localparam int T_CSR_NS = 5;
	localparam int T_CHR_NS = 20;
	localparam int T_RAS_NS = 80;
	localparam int T_ACC_NS = 80;
	localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RSH_CYC = (T_RSH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_CSR_CYC = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_CHR_CYC = (T_CHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	// Long times in us; cycle counts are top-level parameters.
	localparam int T_PWRUP_US = 200;
	localparam int T_REF_WIN_US = 16000;
	localparam int REF_ROWS = 1024;
	localparam int INIT_CYCLES = 8;
	localparam int PWRUP_CYC = T_PWRUP_US * CLK_MHZ;
	// Row interval rounded down so the window is never exceeded.
	localparam int REF_INT_CYC = (T_REF_WIN_US * CLK_MHZ) / REF_ROWS;
	localparam int CNT_W = 16;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_TEST_ENTER = 2'h2;
	localparam logic [1:0] CMD_TEST_EXIT = 2'h3;
	typedef enum logic [3:0] {
		ST_PWRUP, ST_IDLE, ST_ROW, ST_COL, ST_CASHI, ST_PRE,
		ST_CBR_CAS, ST_CBR_RAS, ST_CBR_END
	} state_t;
endpackage

// File: src/edo_dram_ctrl.sv
// Controller that drives an asynchronous EDO memory through its strobes and pins.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] Twenty-bit address split into row and column.
// [R2] Device latches row then column on falling strobes.
// [R3] Address set up before each strobe falls.
// [R4] Output held after column strobe rises.
// [R5] Page access needs new column per cycle.
// [R6] Output enable low drives read data.
// [R7] Output enable high before column rise floats.
// [R8] Output enable pulse during column-high floats.
// [R9] Write select high reads, low writes.
// [R10] Early write keeps outputs floating.
// [R11] Write select low floats page read.
// [R12] Write data taken at later falling edge.
// [R13] Refresh all 1024 rows every 16 ms.
// [R14] Ordinary cycles refresh their opened row.
// [R15] Row-only refresh keeps column strobe high.
// [R16] Hidden refresh keeps column strobe low.
// [R17] Column-first refresh uses internal counter.
// [R18] Long column-first low enters self refresh.
// [R19] Leave self refresh, then burst refresh.
// [R20] Wait 200 us, then eight init cycles.
// [R21] Column-first with write low enters test.
// [R22] Test mode compares eight sections in parallel.
// [R23] Reads return last written value.
module edo_dram_ctrl #(
	parameter int PWRUP_CYC = edo_ctrl_pkg::PWRUP_CYC,
	parameter int REF_INT_CYC = edo_ctrl_pkg::REF_INT_CYC
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic [1:0] REQ_CMD,
	input wire logic [edo_ctrl_pkg::ADDR_W-1:0] REQ_ADDR,
	input wire logic [edo_ctrl_pkg::DATA_W-1:0] REQ_WDATA,
	output logic RD_VALID,
	output logic [edo_ctrl_pkg::DATA_W-1:0] RD_DATA,
	output logic INIT_DONE,
	output logic TEST_MODE,
	output logic ROW_STROBE_N,
	output logic COLUMN_STROBE_N,
	output logic STORE_SELECT_N,
	output logic OUT_DRIVE_N,
	output logic [edo_ctrl_pkg::ROW_W-1:0] ADDR_PINS,
	input wire logic [edo_ctrl_pkg::DATA_W-1:0] DATA_PINS_I,
	output logic [edo_ctrl_pkg::DATA_W-1:0] DATA_PINS_O,
	output logic DATA_PINS_OE
);
	localparam logic [edo_ctrl_pkg::CNT_W-1:0] ONE = 16'h0001;
	edo_ctrl_pkg::state_t state_q;
	logic [edo_ctrl_pkg::CNT_W-1:0] wait_q;
	logic [edo_ctrl_pkg::CNT_W-1:0] ref_tmr_q;
	logic ref_due_q;
	logic [3:0] init_cnt_q;
	logic is_write_q;
	logic is_test_q;
	logic [edo_ctrl_pkg::COL_W-1:0] col_q;
	logic [edo_ctrl_pkg::DATA_W-1:0] wdata_q;
	logic [edo_ctrl_pkg::DATA_W-1:0] dq_s1_q;
	logic [edo_ctrl_pkg::DATA_W-1:0] dq_s2_q;
	logic [edo_ctrl_pkg::DATA_W-1:0] dq_s3_q;
	logic take;
	logic wait_done;

	function automatic logic [edo_ctrl_pkg::CNT_W-1:0] cyc(input int n);
		cyc = edo_ctrl_pkg::CNT_W'(n);
	endfunction

	assign wait_done = (wait_q == '0);
	assign take = REQ_VALID && REQ_READY;
	// Refresh takes priority over user requests.
	assign REQ_READY = (state_q == edo_ctrl_pkg::ST_IDLE) && INIT_DONE && !ref_due_q;

	// ====================================================================
	// Data pin input synchroniser.
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			dq_s3_q <= '0;
		end else begin
			dq_s1_q <= DATA_PINS_I;
			dq_s2_q <= dq_s1_q;
			dq_s3_q <= dq_s2_q;
		end
	end

	// ====================================================================
	// Refresh interval timer; one row due per interval.
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			ref_tmr_q <= '0;
			ref_due_q <= 1'b0;
		end else begin
			if (ref_tmr_q >= cyc(REF_INT_CYC - 1)) begin
				ref_tmr_q <= '0;
				ref_due_q <= 1'b1; // [R13]
			end else begin
				ref_tmr_q <= ref_tmr_q + ONE;
				// Only the end of a column-first refresh settles the due row; a read or
				// write also passes through precharge but refreshes a row of its own.
				if (state_q == edo_ctrl_pkg::ST_CBR_RAS && wait_done && !ROW_STROBE_N
						&& !is_test_q) begin
					ref_due_q <= 1'b0; // [R13]
				end
			end
		end
	end

	// ====================================================================
	// Main sequencer.
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			state_q <= edo_ctrl_pkg::ST_PWRUP;
			wait_q <= '0;
			init_cnt_q <= '0;
			INIT_DONE <= 1'b0;
			TEST_MODE <= 1'b0;
			is_write_q <= 1'b0;
			is_test_q <= 1'b0;
			col_q <= '0;
			wdata_q <= '0;
			RD_VALID <= 1'b0;
			RD_DATA <= '0;
			ROW_STROBE_N <= 1'b1;
			COLUMN_STROBE_N <= 1'b1;
			STORE_SELECT_N <= 1'b1;
			OUT_DRIVE_N <= 1'b1;
			ADDR_PINS <= '0;
			DATA_PINS_O <= '0;
			DATA_PINS_OE <= 1'b0;
		end else begin
			RD_VALID <= 1'b0;
			if (!wait_done) begin
				wait_q <= wait_q - ONE;
			end
			case (state_q)
				edo_ctrl_pkg::ST_PWRUP: begin
					if (wait_q == '0 && init_cnt_q == '0 && !INIT_DONE) begin
						wait_q <= cyc(PWRUP_CYC); // [R20]
						init_cnt_q <= 4'h1;
					end else if (wait_done) begin
						state_q <= edo_ctrl_pkg::ST_CBR_CAS;
					end
				end
				edo_ctrl_pkg::ST_IDLE: begin
					if (ref_due_q) begin
						// Every refresh is column-first: no row-only, hidden or self refresh
						// is ever started, so none has to be left or made up for.
						state_q <= edo_ctrl_pkg::ST_CBR_CAS; // [R13] [R15] [R16] [R19]
					end else if (take) begin
						// Row half goes out first; column half is kept. [R1]
						ADDR_PINS <= REQ_ADDR[edo_ctrl_pkg::ADDR_W-1:edo_ctrl_pkg::COL_W]; // [R3]
						col_q <= REQ_ADDR[edo_ctrl_pkg::COL_W-1:0];
						wdata_q <= REQ_WDATA;
						is_write_q <= (REQ_CMD == edo_ctrl_pkg::CMD_WRITE);
						if (REQ_CMD == edo_ctrl_pkg::CMD_READ || REQ_CMD == edo_ctrl_pkg::CMD_WRITE) begin
							state_q <= edo_ctrl_pkg::ST_ROW;
						end else begin
							is_test_q <= (REQ_CMD == edo_ctrl_pkg::CMD_TEST_ENTER);
							state_q <= edo_ctrl_pkg::ST_CBR_CAS;
						end
					end
				end
				edo_ctrl_pkg::ST_ROW: begin
					ROW_STROBE_N <= 1'b0; // [R2] [R14]
					wait_q <= cyc(edo_ctrl_pkg::T_RCD_CYC);
					state_q <= edo_ctrl_pkg::ST_COL;
					// Early write: select low before the column strobe falls. [R10]
					STORE_SELECT_N <= !is_write_q; // [R9]
					if (is_write_q) begin
						DATA_PINS_O <= wdata_q; // [R12]
						DATA_PINS_OE <= 1'b1;
					end
				end
				edo_ctrl_pkg::ST_COL: begin
					if (wait_done && COLUMN_STROBE_N) begin
						if (ADDR_PINS != col_q) begin
							ADDR_PINS <= col_q; // [R3]
						end else begin
							COLUMN_STROBE_N <= 1'b0; // [R2]
							OUT_DRIVE_N <= is_write_q; // [R6]
							wait_q <= cyc(edo_ctrl_pkg::T_ACC_CYC);
						end
					end else if (wait_done && !COLUMN_STROBE_N) begin
						state_q <= edo_ctrl_pkg::ST_CASHI;
					end
				end
				edo_ctrl_pkg::ST_CASHI: begin
					// Sample is taken after the column strobe rises, where output still holds. [R4]
					COLUMN_STROBE_N <= 1'b1;
					wait_q <= cyc(edo_ctrl_pkg::T_RSH_CYC + 2);
					state_q <= edo_ctrl_pkg::ST_PRE;
				end
				edo_ctrl_pkg::ST_PRE: begin
					if (wait_done) begin
						if (!is_write_q) begin
							RD_DATA <= dq_s3_q; // [R23]
							RD_VALID <= 1'b1;
						end
						ROW_STROBE_N <= 1'b1;
						OUT_DRIVE_N <= 1'b1; // [R7]
						STORE_SELECT_N <= 1'b1;
						DATA_PINS_OE <= 1'b0;
						wait_q <= cyc(edo_ctrl_pkg::T_RP_CYC);
						state_q <= edo_ctrl_pkg::ST_CBR_END;
					end
				end
				edo_ctrl_pkg::ST_CBR_CAS: begin
					if (wait_done) begin
						// Column strobe leads the row strobe. [R17]
						COLUMN_STROBE_N <= 1'b0;
						STORE_SELECT_N <= !is_test_q; // [R21]
						wait_q <= cyc(edo_ctrl_pkg::T_CSR_CYC);
						state_q <= edo_ctrl_pkg::ST_CBR_RAS;
					end
				end
				edo_ctrl_pkg::ST_CBR_RAS: begin
					if (wait_done && ROW_STROBE_N) begin
						ROW_STROBE_N <= 1'b0;
						wait_q <= cyc(edo_ctrl_pkg::T_RAS_CYC);
					end else if (wait_done) begin
						// Held well below the self-refresh entry time. [R18]
						ROW_STROBE_N <= 1'b1;
						COLUMN_STROBE_N <= 1'b1;
						STORE_SELECT_N <= 1'b1;
						wait_q <= cyc(edo_ctrl_pkg::T_RP_CYC);
						state_q <= edo_ctrl_pkg::ST_CBR_END;
						if (is_test_q) begin
							TEST_MODE <= 1'b1; // [R21]
						end else if (state_q == edo_ctrl_pkg::ST_CBR_RAS) begin
							TEST_MODE <= 1'b0;
						end
					end
				end
				edo_ctrl_pkg::ST_CBR_END: begin
					if (wait_done) begin
						is_test_q <= 1'b0;
						if (!INIT_DONE) begin
							if (init_cnt_q >= 4'(edo_ctrl_pkg::INIT_CYCLES)) begin
								INIT_DONE <= 1'b1; // [R20]
								state_q <= edo_ctrl_pkg::ST_IDLE;
							end else begin
								init_cnt_q <= init_cnt_q + 4'h1;
								state_q <= edo_ctrl_pkg::ST_CBR_CAS;
							end
						end else begin
							state_q <= edo_ctrl_pkg::ST_IDLE;
						end
					end
				end
				default: state_q <= edo_ctrl_pkg::ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: verification/edo_ctrl_monitor.sv
// Assertion checker for the pin sequencing of the memory controller.
`timescale 1ns/1ps
`default_nettype none
module edo_ctrl_monitor #(
	parameter int REF_INT_CYC = 40
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic REQ_READY,
	input wire logic RD_VALID,
	input wire logic INIT_DONE,
	input wire logic TEST_MODE,
	input wire logic ROW_STROBE_N,
	input wire logic COLUMN_STROBE_N,
	input wire logic STORE_SELECT_N,
	input wire logic OUT_DRIVE_N,
	input wire logic [edo_ctrl_pkg::ROW_W-1:0] ADDR_PINS,
	input wire logic DATA_PINS_OE
);
	// Self refresh would start after 100 us with both strobes low, 2000 cycles.
	localparam logic [15:0] SELF_REF_CYC = 16'h07d0;
	logic [15:0] gap_q;
	logic [15:0] both_low_q;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// Counts cycles since the last column-first refresh.
	always_ff @(posedge REF_CLK) begin
		if (!NRST || (!COLUMN_STROBE_N && ROW_STROBE_N)) begin
			gap_q <= 16'h0;
		end else begin
			gap_q <= gap_q + 16'h1;
		end
	end
	// Counts cycles with both strobes low.
	always_ff @(posedge REF_CLK) begin
		if (!NRST || ROW_STROBE_N || COLUMN_STROBE_N) begin
			both_low_q <= 16'h0;
		end else if (both_low_q != 16'hffff) begin
			both_low_q <= both_low_q + 16'h1;
		end
	end
	a_reset_idle: assert property ($rose(NRST) |-> ROW_STROBE_N && COLUMN_STROBE_N
		&& !DATA_PINS_OE && !REQ_READY) else $error("outputs not idle after reset");
	a_ready_init: assert property (REQ_READY |-> INIT_DONE)
		else $error("ready before init");
	a_addr_setup: assert property (($fell(ROW_STROBE_N) && COLUMN_STROBE_N)
		|| ($fell(COLUMN_STROBE_N) && !ROW_STROBE_N) |-> $stable(ADDR_PINS))
		else $error("address moved at strobe");
	a_early_write: assert property (!STORE_SELECT_N && !ROW_STROBE_N |-> OUT_DRIVE_N)
		else $error("output enabled in write");
	a_write_data: assert property ($fell(COLUMN_STROBE_N) && !STORE_SELECT_N
		&& !ROW_STROBE_N |-> DATA_PINS_OE) else $error("no write data");
	a_no_contention: assert property (!OUT_DRIVE_N |-> !DATA_PINS_OE && STORE_SELECT_N)
		else $error("pins driven in read");
	a_cbr_setup: assert property ($fell(ROW_STROBE_N) && !COLUMN_STROBE_N
		|-> $past(COLUMN_STROBE_N) == 1'b0) else $error("column strobe late");
	a_cbr_hold: assert property ($fell(ROW_STROBE_N) && !COLUMN_STROBE_N
		|=> !COLUMN_STROBE_N) else $error("column strobe released early");
	a_row_first: assert property ($fell(COLUMN_STROBE_N) && !ROW_STROBE_N
		|-> $past(ROW_STROBE_N, 2) == 1'b0) else $error("row to column too short");
	a_refresh_gap: assert property (INIT_DONE |-> gap_q <= 16'(REF_INT_CYC + 32))
		else $error("refresh overdue");
	a_no_self_refresh: assert property (both_low_q < SELF_REF_CYC)
		else $error("strobes low long enough for self refresh");
	cover property ($rose(RD_VALID));
	cover property ($rose(TEST_MODE));
	cover property ($fell(COLUMN_STROBE_N) && !STORE_SELECT_N);
	cover property ($fell(ROW_STROBE_N) && !COLUMN_STROBE_N);
endmodule
bind edo_dram_ctrl edo_ctrl_monitor #(.REF_INT_CYC(REF_INT_CYC)) u_edo_ctrl_monitor (
	.REF_CLK, .NRST, .REQ_READY, .RD_VALID, .INIT_DONE, .TEST_MODE, .ROW_STROBE_N,
	.COLUMN_STROBE_N, .STORE_SELECT_N, .OUT_DRIVE_N, .ADDR_PINS, .DATA_PINS_OE);
`default_nettype wire

// File: verification/edo_mem_model.sv
// Behavioural model of the four-bit page-mode memory at the far side.
`timescale 1ns/1ps
`default_nettype none
module edo_mem_model (
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [9:0] addr,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic test_q,
	output logic [15:0] refs
);
	logic [3:0] mem [logic [19:0]];
	logic [9:0] row = 10'h0;
	logic [9:0] col = 10'h0;
	logic [3:0] dout = 4'h0;
	logic drive = 1'b0;
	initial test_q = 1'b0;
	initial refs = 16'h0;
	// Released pins show the inverse of the last value.
	assign dq_out = (drive && !oe_n) ? dout : ~dout;
	always @(negedge ras_n) begin
		if (cas_n) begin
			row = addr;
		end else begin
			refs = refs + 16'h1;
			test_q = !we_n;
		end
	end
	// In test mode the first pin is copied to every bit, and a read reports agreement.
	always @(negedge cas_n) begin
		if (!ras_n) begin
			col = addr;
			if (!we_n) begin
				mem[{row, col}] = test_q ? {4{dq_in[0]}} : dq_in;
			end else begin
				dout = mem.exists({row, col}) ? mem[{row, col}] : 4'h0;
				if (test_q) begin
					dout = (dout == 4'h0 || dout == 4'hf) ? 4'hf : 4'h0;
				end
				drive = 1'b1;
			end
		end
	end
	always @(negedge we_n) begin
		drive = 1'b0;
		if (!ras_n && !cas_n) begin
			mem[{row, col}] = test_q ? {4{dq_in[0]}} : dq_in;
		end
	end
	always @(posedge ras_n or posedge oe_n) begin
		if (cas_n) begin
			drive = 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking testbench of the memory controller against the memory model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic valid = 1'b0;
	logic [1:0] cmd = 2'h0;
	logic [19:0] addr = 20'h0;
	logic [3:0] wdata = 4'h0;
	logic ready, rd_valid, init_done, test_mode, ras_n, cas_n, we_n, oe_n, dq_oe, m_test;
	logic [3:0] rd_data, dq_o, dq_m, dq_i;
	logic [9:0] apins;
	logic [15:0] refs;
	int failures = 0;
	int tests_run = 0;
	always #25 clk = ~clk;
	assign dq_i = dq_oe ? dq_o : dq_m;
	edo_dram_ctrl #(.PWRUP_CYC(20), .REF_INT_CYC(40)) u_edo_dram_ctrl (
		.REF_CLK(clk), .NRST(nrst), .REQ_VALID(valid), .REQ_READY(ready), .REQ_CMD(cmd),
		.REQ_ADDR(addr), .REQ_WDATA(wdata), .RD_VALID(rd_valid), .RD_DATA(rd_data),
		.INIT_DONE(init_done), .TEST_MODE(test_mode), .ROW_STROBE_N(ras_n),
		.COLUMN_STROBE_N(cas_n), .STORE_SELECT_N(we_n), .OUT_DRIVE_N(oe_n),
		.ADDR_PINS(apins), .DATA_PINS_I(dq_i), .DATA_PINS_O(dq_o), .DATA_PINS_OE(dq_oe));
	edo_mem_model u_edo_mem_model (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
		.addr(apins), .dq_in(dq_i), .dq_out(dq_m), .test_q(m_test), .refs(refs));
	task automatic note_mismatch(input string msg);
		failures++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask
	task automatic idle;
		int n = 0;
		while (ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic req(input logic [1:0] c, input logic [19:0] a, input logic [3:0] d);
		@(negedge clk);
		cmd = c;
		addr = a;
		wdata = d;
		valid = 1'b1;
		idle();
		tests_run++;
		if (ready !== 1'b1) note_mismatch("request not accepted");
		@(negedge clk);
		valid = 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [3:0] exp);
		int n = 0;
		req(edo_ctrl_pkg::CMD_READ, a, 4'h0);
		while (rd_valid !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		tests_run++;
		if (rd_valid !== 1'b1 || rd_data !== exp) note_mismatch("read data");
	endtask
	task automatic t_init;
		int n = 0;
		tests_run++;
		if (ras_n !== 1'b1 || cas_n !== 1'b1 || ready !== 1'b0) note_mismatch("reset levels");
		nrst = 1'b1;
		repeat (15) @(negedge clk);
		tests_run++;
		if (refs !== 16'h0 || init_done !== 1'b0) note_mismatch("cycles during pause");
		while (init_done !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		tests_run++;
		if (init_done !== 1'b1 || refs < 16'h8) note_mismatch("init cycles");
		// A refresh that fell due during the init cycles may run before the first request.
		idle();
		tests_run++;
		if (ready !== 1'b1) note_mismatch("not ready after init");
		$display("t_init done");
	endtask
	task automatic t_rw;
		logic [19:0] a [4] = '{20'h00000, 20'hfffff, 20'h5a3c1, 20'h003ff};
		logic [3:0] d [4] = '{4'h3, 4'h8, 4'hd, 4'h2};
		foreach (a[i]) req(edo_ctrl_pkg::CMD_WRITE, a[i], d[i]);
		foreach (a[i]) rd(a[i], d[i]);
		req(edo_ctrl_pkg::CMD_WRITE, a[1], 4'h6);
		rd(a[1], 4'h6);
		$display("t_rw done");
	endtask
	task automatic t_test;
		int n = 0;
		req(edo_ctrl_pkg::CMD_TEST_ENTER, 20'h0, 4'h0);
		// Any later refresh ends test mode again, so look as soon as it is entered.
		while (test_mode !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		tests_run++;
		if (test_mode !== 1'b1 || m_test !== 1'b1) note_mismatch("test entry");
		req(edo_ctrl_pkg::CMD_TEST_EXIT, 20'h0, 4'h0);
		idle();
		tests_run++;
		if (test_mode !== 1'b0 || m_test !== 1'b0) note_mismatch("test exit");
		$display("t_test done");
	endtask
	task automatic t_refresh;
		logic [15:0] r0;
		r0 = refs;
		repeat (200) @(negedge clk);
		tests_run++;
		if (refs - r0 < 16'h4) note_mismatch("refresh rate");
		rd(20'hfffff, 4'h6);
		$display("t_refresh done");
	endtask
	task automatic print_verdict;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		t_init();
		t_rw();
		t_test();
		t_refresh();
		print_verdict();
	end
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
